//--- rtl/power_mode_pkg.sv
package power_mode_pkg;

  // Sizes of the controlled system
  localparam int NUM_BLOCKS = 4;   // Functional blocks with run/idle control
  localparam int RAM_BLOCKS = 2;   // Retainable RAM blocks of 8 kB each
  localparam int PIN_SYNC_W = 6;   // Pins passed through the synchroniser

  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL       = 8'h00;
  localparam logic [7:0] ADDR_RETAIN     = 8'h04;
  localparam logic [7:0] ADDR_OFF_CMD    = 8'h08;
  localparam logic [7:0] ADDR_WAKE_CFG   = 8'h0C;
  localparam logic [7:0] ADDR_STATUS     = 8'h10;
  localparam logic [7:0] ADDR_WAKE_CAUSE = 8'h14;

  // Control register fields
  localparam int CTRL_W            = 5;
  localparam int CTRL_CONST_LAT    = 0;  // 1: constant latency, 0: low power
  localparam int CTRL_HF_XTAL      = 1;  // 1: crystal, 0: RC oscillator
  localparam int CTRL_XTAL_32M     = 2;  // Crystal high frequency option
  localparam int CTRL_BUCK_EN      = 3;  // Buck converter enable
  localparam int CTRL_LDO_ONLY     = 4;  // Linear regulator only supply
  localparam logic [4:0] CTRL_RESET = 5'h00;

  // Other fields and reset values
  localparam int OFF_CMD_BIT       = 0;
  localparam int WAKE_GPIO         = 0;
  localparam int WAKE_COMP         = 1;
  localparam logic [1:0] WAKE_CFG_RESET = 2'h0;
  localparam logic [1:0] RETAIN_RESET   = 2'h0;
  localparam int CAUSE_RESET       = 0;
  localparam int CAUSE_GPIO        = 1;
  localparam int CAUSE_COMP        = 2;
  localparam logic [2:0] CAUSE_AT_RESET = 3'h1;

  // Global power states
  typedef enum logic [3:0] {
    ST_ON    = 4'h1,
    ST_ABORT = 4'h2,
    ST_OFF   = 4'h4,
    ST_WAKE  = 4'h8
  } sys_state_e;

  // Register port request
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_s;

  // Ready levels from the analog resources
  typedef struct packed {
    logic primary;
    logic secondary;
    logic rc;
    logic xtal;
  } res_ready_s;

  // Enables towards the analog resources
  typedef struct packed {
    logic primary;
    logic secondary;
    logic rc;
    logic xtal;
    logic xtal_32m;
  } res_enable_s;

  // Ready of the selected high frequency source
  function automatic logic clk_ready(input res_ready_s r, input logic use_xtal);
    clk_ready = use_xtal ? r.xtal : r.rc;
  endfunction : clk_ready

endpackage : power_mode_pkg

//--- rtl/system_power_mode_control.sv
// Decided for this implementation: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
// Notes on behaviour
// [R01] Off entry: core powered down, tasks aborted
// [R02] In off only pin wake responds
// [R03] Reset, GPIO or comparator wake to on
// [R04] RAM retention chosen per 8 kB block
// [R05] Each block runs or idles independently
// [R06] Two sleep sub-modes: low power, constant latency
// [R07] Low power: resources off when unneeded
// [R08] Low power: tasks wait for resources ready
// [R09] Constant latency: regulators and clock forced on
// [R10] Buck suspended between radio events
// [R11] Linear only: buck bypassed and disabled
// [R12] Software drops buck at low supply
// [R13] Wake restarts core by reset, keeps retention
module system_power_mode_control
  import power_mode_pkg::*;
(
  input  wire logic                          clock,
  input  wire logic                          sys_rst,
  input  wire power_mode_pkg::bus_req_s      bus,
  output logic      [31:0]                   rd_data,
  input  wire logic                          cpu_sleep,
  input  wire logic [power_mode_pkg::NUM_BLOCKS-1:0] blk_need,
  input  wire logic [power_mode_pkg::NUM_BLOCKS-1:0] task_req,
  input  wire logic                          radio_active,
  input  wire logic                          gpio_detect_pin,
  input  wire logic                          comparator_wake_signal,
  input  wire power_mode_pkg::res_ready_s    res_ready_pin,
  output logic                               core_power_on,
  output logic                               core_reset_req,
  output logic                               abort_tasks,
  output logic      [power_mode_pkg::RAM_BLOCKS-1:0] ram_power,
  output logic      [power_mode_pkg::NUM_BLOCKS-1:0] blk_run,
  output logic      [power_mode_pkg::NUM_BLOCKS-1:0] task_grant,
  output power_mode_pkg::res_enable_s        res_enable,
  output logic                               buck_converter_en,
  output logic                               buck_bypass,
  output logic      [1:0]                    wake_detect_en
);

  import power_mode_pkg::*;

  // Synchronised pin levels
  logic [PIN_SYNC_W-1:0] pin_sync;   // GPIO, comparator and ready levels after two flops
  logic                  gpio_s;     // GPIO level detect
  logic                  comp_s;     // Comparator wake detect
  res_ready_s            ready_s;    // Resource ready levels

  // Power state
  sys_state_e            state_q;    // Current global state
  sys_state_e            state_d;    // Next global state
  logic                  sys_on;     // Fully operational state
  logic                  off_cmd;    // Software asks for off
  logic                  wake_gpio;  // Enabled GPIO wake seen
  logic                  wake_comp;  // Enabled comparator wake seen
  logic                  wake_hit;   // Any enabled wake cause

  // Software registers
  logic [CTRL_W-1:0]     ctrl_q;     // Supply and sleep control
  logic [RAM_BLOCKS-1:0] retain_q;   // RAM blocks kept in off
  logic [1:0]            wake_cfg_q; // Wake sources armed in off
  logic [2:0]            cause_q;    // Sticky wake causes
  logic [31:0]           rd_data_q;  // Read data, one cycle late
  logic [31:0]           rd_mux;     // Selected read value
  logic                  reg_wr;     // Write accepted while on
  logic [2:0]            cause_clr;  // Write-one-to-clear mask
  logic [2:0]            cause_set;  // Causes caught this cycle

  // Resource control
  logic                  needed;     // Something requires resources
  logic                  want_res;   // Resources to be enabled
  logic                  use_xtal;   // Crystal chosen as clock source
  logic                  res_ok;     // All needed resources ready
  logic [NUM_BLOCKS-1:0] pending;    // Tasks waiting in the gate
  logic [NUM_BLOCKS-1:0] grant;      // Task start pulses

  // Output flops
  logic                  core_power_q;
  logic                  core_reset_q;
  logic                  abort_q;
  logic [RAM_BLOCKS-1:0] ram_power_q;
  logic [NUM_BLOCKS-1:0] blk_run_q;
  res_enable_s           res_en_q;
  logic                  buck_en_q;
  logic                  bypass_q;
  logic [1:0]            wake_det_q;

  // Outside levels pass two flops before use
  two_flop_sync #(
    .WIDTH (PIN_SYNC_W)
  ) u_pin_sync (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .async_in ({gpio_detect_pin, comparator_wake_signal, res_ready_pin}),
    .sync_out (pin_sync)
  );

  assign gpio_s  = pin_sync[5];
  assign comp_s  = pin_sync[4];
  assign ready_s = res_ready_s'(pin_sync[3:0]);

  // State decode and wake detection
  assign sys_on    = (state_q == ST_ON);
  assign off_cmd   = sys_on && bus.wr && (bus.addr == ADDR_OFF_CMD) && bus.wdata[OFF_CMD_BIT];
  assign wake_gpio = gpio_s && wake_cfg_q[WAKE_GPIO];  // see [R03]
  assign wake_comp = comp_s && wake_cfg_q[WAKE_COMP];  // see [R03]
  assign wake_hit  = wake_gpio || wake_comp;

  // Global state transitions
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_ON: begin
        // Off request drops the core and kills tasks
        if (off_cmd) begin
          state_d = ST_ABORT;  // see [R01]
        end
      end
      ST_ABORT: begin
        state_d = ST_OFF;
      end
      ST_OFF: begin
        // Only an armed pin wake leaves off
        if (wake_hit) begin
          state_d = ST_WAKE;  // see [R02]
        end
      end
      ST_WAKE: begin
        // Core restarts through its reset
        state_d = ST_ON;  // see [R13]
      end
      default: begin
        state_d = ST_ON;
      end
    endcase
  end

  // State register; reset itself is a wake to on
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_q <= ST_ON;  // see [R03]
    end else begin
      state_q <= state_d;
    end
  end

  // Register writes are ignored outside the on state
  assign reg_wr = sys_on && bus.wr;

  // Control register
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ctrl_q <= CTRL_RESET;
    end else if (reg_wr && (bus.addr == ADDR_CTRL)) begin
      ctrl_q <= bus.wdata[CTRL_W-1:0];  // see [R06]
    end
  end

  // RAM retention selection, one bit per block
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      retain_q <= RETAIN_RESET;
    end else if (reg_wr && (bus.addr == ADDR_RETAIN)) begin
      retain_q <= bus.wdata[RAM_BLOCKS-1:0];  // see [R04]
    end
  end

  // Wake source arming
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wake_cfg_q <= WAKE_CFG_RESET;
    end else if (reg_wr && (bus.addr == ADDR_WAKE_CFG)) begin
      wake_cfg_q <= bus.wdata[1:0];
    end
  end

  // Sticky wake causes, a new cause beats a clear
  assign cause_clr = (reg_wr && (bus.addr == ADDR_WAKE_CAUSE)) ? bus.wdata[2:0] : 3'h0;
  assign cause_set = (state_q == ST_OFF) ? {wake_comp, wake_gpio, 1'b0} : 3'h0;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cause_q <= CAUSE_AT_RESET;
    end else begin
      cause_q <= (cause_q & ~cause_clr) | cause_set;
    end
  end

  // Read multiplexer; unmapped addresses read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (bus.addr)
      ADDR_CTRL:       rd_mux[CTRL_W-1:0]     = ctrl_q;
      ADDR_RETAIN:     rd_mux[RAM_BLOCKS-1:0] = retain_q;
      ADDR_WAKE_CFG:   rd_mux[1:0]            = wake_cfg_q;
      ADDR_STATUS:     rd_mux[8:0]            = {res_ok, state_q, ready_s};
      ADDR_WAKE_CAUSE: rd_mux[2:0]            = cause_q;
      default:         rd_mux                 = 32'h0000_0000;
    endcase
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rd_data_q <= 32'h0000_0000;
    end else begin
      rd_data_q <= bus.rd ? rd_mux : 32'h0000_0000;
    end
  end

  // Resource demand: awake CPU, a running block or a waiting task
  assign use_xtal = ctrl_q[CTRL_HF_XTAL];
  assign needed   = !cpu_sleep || (|blk_need) || (|pending);
  assign want_res = sys_on && (ctrl_q[CTRL_CONST_LAT] || needed);  // see [R07] see [R09]

  // Tasks start only with regulators and clock running
  assign res_ok = res_en_q.primary && ready_s.primary && ready_s.secondary
                  && clk_ready(ready_s, use_xtal);  // see [R08]

  // Regulator and oscillator enables
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      res_en_q <= '0;
    end else begin
      res_en_q.primary   <= want_res;              // see [R09]
      res_en_q.secondary <= want_res;              // see [R09]
      res_en_q.rc        <= want_res && !use_xtal; // see [R07]
      res_en_q.xtal      <= want_res && use_xtal;  // see [R07]
      res_en_q.xtal_32m  <= ctrl_q[CTRL_XTAL_32M];
    end
  end

  // Buck runs only during radio events, never in linear-only supply
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      buck_en_q <= 1'b0;
      bypass_q  <= 1'b1;
    end else begin
      buck_en_q <= sys_on && ctrl_q[CTRL_BUCK_EN] && !ctrl_q[CTRL_LDO_ONLY]
                   && radio_active;                         // see [R10] see [R11]
      bypass_q  <= !(sys_on && ctrl_q[CTRL_BUCK_EN] && !ctrl_q[CTRL_LDO_ONLY]
                   && radio_active);                        // see [R11]
    end
  end

  // Task gate holds tasks until resources are ready
  task_gate u_task_gate (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .task_req (sys_on ? task_req : '0),
    .res_ok   (res_ok),
    .abort    (!sys_on || off_cmd),  // see [R01]
    .pending  (pending),
    .grant    (grant)
  );

  // Per-block run or idle
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      blk_run_q <= '0;
    end else begin
      blk_run_q <= sys_on ? (blk_need | pending) : '0;  // see [R05]
    end
  end

  // Core power, abort pulse and core restart
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      core_power_q <= 1'b1;
      abort_q      <= 1'b0;
      core_reset_q <= 1'b1;
    end else begin
      core_power_q <= (state_d == ST_ON) || (state_d == ST_WAKE);  // see [R01]
      abort_q      <= (state_d == ST_ABORT);                         // see [R01]
      core_reset_q <= (state_d == ST_WAKE);                          // see [R13]
    end
  end

  // RAM supply: all on, only retained blocks in abort and off
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ram_power_q <= {RAM_BLOCKS{1'b1}};
    end else begin
      ram_power_q <= ((state_d == ST_ABORT) || (state_d == ST_OFF)) ? retain_q
                     : {RAM_BLOCKS{1'b1}};  // see [R04] see [R13]
    end
  end

  // Pin wake detectors armed only in off
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wake_det_q <= 2'h0;
    end else begin
      wake_det_q <= (state_d == ST_OFF) ? wake_cfg_q : 2'h0;  // see [R02]
    end
  end

  assign rd_data           = rd_data_q;
  assign core_power_on     = core_power_q;
  assign core_reset_req    = core_reset_q;
  assign abort_tasks       = abort_q;
  assign ram_power         = ram_power_q;
  assign blk_run           = blk_run_q;
  assign task_grant        = grant;
  assign res_enable        = res_en_q;
  assign buck_converter_en = buck_en_q;
  assign buck_bypass       = bypass_q;
  assign wake_detect_en    = wake_det_q;

  // Abort state drops core power and pulses abort
  property p_off_entry;
    @(posedge clock) disable iff (sys_rst)
    (state_q == ST_ABORT) |-> (abort_tasks && !core_power_on && task_grant == '0);
  endproperty
  a_off_entry: assert property (p_off_entry) else $error("off entry not clean"); // see [R01]

  // In off wake detection stays armed; primary regulator, buck and all blocks are off
  property p_off_quiet;
    @(posedge clock) disable iff (sys_rst)
    (state_q == ST_OFF) |-> (wake_detect_en == wake_cfg_q && !res_enable.primary
                             && !buck_converter_en && blk_run == '0);
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("activity in off"); // see [R02]

  // Armed wake leads to on within two cycles
  property p_wake;
    @(posedge clock) disable iff (sys_rst)
    (state_q == ST_OFF && wake_hit) |=> (state_q == ST_WAKE) ##1 (state_q == ST_ON);
  endproperty
  a_wake: assert property (p_wake) else $error("wake not taken"); // see [R03]

  // Only retained RAM blocks powered in off
  property p_retain;
    @(posedge clock) disable iff (sys_rst)
    (state_q == ST_OFF) |-> (ram_power == retain_q);
  endproperty
  a_retain: assert property (p_retain) else $error("retention wrong"); // see [R04]

  // Block run follows need of the previous cycle
  property p_blk_run;
    @(posedge clock) disable iff (sys_rst)
    (sys_on) |=> (blk_run == ($past(blk_need) | $past(pending)));
  endproperty
  a_blk_run: assert property (p_blk_run) else $error("block run wrong"); // see [R05]

  // Constant latency keeps regulators and one clock on
  property p_const_lat;
    @(posedge clock) disable iff (sys_rst)
    (sys_on && ctrl_q[CTRL_CONST_LAT]) |=>
      (res_enable.primary && res_enable.secondary && (res_enable.rc != res_enable.xtal));
  endproperty
  a_const_lat: assert property (p_const_lat) else $error("base resources off"); // see [R09]

  // Low power with nothing needed turns resources off
  property p_low_power;
    @(posedge clock) disable iff (sys_rst)
    (!ctrl_q[CTRL_CONST_LAT] && !needed) |=> (!res_enable.primary && !res_enable.rc);
  endproperty
  a_low_power: assert property (p_low_power) else $error("idle resource on"); // see [R07]

  // A task starts only after resources were ready
  property p_task_wait;
    @(posedge clock) disable iff (sys_rst)
    (task_grant != '0) |-> ($past(res_ok) && (($past(pending) & task_grant) == task_grant));
  endproperty
  a_task_wait: assert property (p_task_wait) else $error("task before ready"); // see [R08]

  // Buck off between radio events
  property p_buck_idle;
    @(posedge clock) disable iff (sys_rst)
    (!radio_active) |=> (!buck_converter_en && buck_bypass);
  endproperty
  a_buck_idle: assert property (p_buck_idle) else $error("buck on without radio"); // see [R10]

  // Linear-only supply keeps buck bypassed
  property p_ldo_only;
    @(posedge clock) disable iff (sys_rst)
    (ctrl_q[CTRL_LDO_ONLY]) |=> (buck_bypass && !buck_converter_en);
  endproperty
  a_ldo_only: assert property (p_ldo_only) else $error("buck on in linear mode"); // see [R11]

  // Wake gives one core reset pulse with power on
  property p_wake_reset;
    @(posedge clock) disable iff (sys_rst)
    $rose(state_q == ST_WAKE) |-> (core_reset_req && core_power_on) ##1 !core_reset_req;
  endproperty
  a_wake_reset: assert property (p_wake_reset) else $error("wake reset missing"); // see [R13]

endmodule : system_power_mode_control

//--- rtl/task_gate.sv
`timescale 1ns/1ps
module task_gate
  import power_mode_pkg::*;
(
  input  wire logic                  clock,
  input  wire logic                  sys_rst,
  input  wire logic [NUM_BLOCKS-1:0] task_req,
  input  wire logic                  res_ok,
  input  wire logic                  abort,
  output logic      [NUM_BLOCKS-1:0] pending,
  output logic      [NUM_BLOCKS-1:0] grant
);

  logic [NUM_BLOCKS-1:0] pending_q;  // Tasks waiting for resources
  logic [NUM_BLOCKS-1:0] grant_q;    // One-cycle start pulses
  logic [NUM_BLOCKS-1:0] grant_now;  // Tasks released this cycle

  // Release waiting tasks only once resources are up
  assign grant_now = pending_q & {NUM_BLOCKS{res_ok}};  // see [R08]

  // Pending set wins over release; abort clears all
  always_ff @(posedge clock) begin
    if (sys_rst || abort) begin
      pending_q <= '0;  // see [R01]
    end else begin
      pending_q <= (pending_q & ~grant_now) | task_req;
    end
  end

  // Start pulse to the block
  always_ff @(posedge clock) begin
    if (sys_rst || abort) begin
      grant_q <= '0;
    end else begin
      grant_q <= grant_now;
    end
  end

  assign pending = pending_q;
  assign grant   = grant_q;

endmodule : task_gate

//--- rtl/two_flop_sync.sv
`timescale 1ns/1ps
module two_flop_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;  // First stage, read only by the second
  logic [WIDTH-1:0] sync_q;  // Second stage, safe to use

  // Two flops in a row against metastability
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule : two_flop_sync

//--- test/res_model.sv
`timescale 1ns/1ps
// Analog resources: ready follows enable after a start-up time, drops when off
module res_model
  import power_mode_pkg::*;
(
  input  wire logic                        clock,
  input  wire logic                        slow,
  input  wire power_mode_pkg::res_enable_s res_enable,
  output power_mode_pkg::res_ready_s       res_ready
);
  import power_mode_pkg::*;

  logic [3:0] en_v;    // Enables in ready order
  logic [3:0] rdy_v;   // Ready levels
  int         cnt [4]; // Start-up counters
  int         lim;     // Start-up time in cycles

  assign en_v = {res_enable.primary, res_enable.secondary, res_enable.rc, res_enable.xtal};
  assign lim = slow ? 20 : 2;
  assign res_ready = rdy_v;

  // Each resource needs its start-up time before it reports ready
  always @(posedge clock) begin
    for (int i = 0; i < 4; i++) begin
      if (!en_v[i]) begin
        cnt[i] <= 0;
      end else if (cnt[i] < lim) begin
        cnt[i] <= cnt[i] + 1;
      end
      rdy_v[i] <= en_v[i] && (cnt[i] >= lim);
    end
  end
endmodule : res_model

//--- test/system_power_mode_control_bench.sv
`timescale 1ns/1ps
module system_power_mode_control_bench;
  import power_mode_pkg::*;

  logic                  clock, sys_rst, cpu_sleep, radio_active, slow;
  logic                  gpio_detect_pin, comparator_wake_signal;
  bus_req_s              bus;
  logic [31:0]           rd_data;
  logic [NUM_BLOCKS-1:0] blk_need, task_req, blk_run, task_grant;
  res_ready_s            res_ready_pin;
  res_enable_s           res_enable;
  logic                  core_power_on, core_reset_req, abort_tasks, buck_converter_en, buck_bypass;
  logic [RAM_BLOCKS-1:0] ram_power;
  logic [1:0]            wake_detect_en;
  int                    bad_count = 0;
  int                    n_tests = 0;

  system_power_mode_control u_system_power_mode_control (
    .clock(clock), .sys_rst(sys_rst), .bus(bus), .rd_data(rd_data), .cpu_sleep(cpu_sleep),
    .blk_need(blk_need), .task_req(task_req), .radio_active(radio_active),
    .gpio_detect_pin(gpio_detect_pin), .comparator_wake_signal(comparator_wake_signal),
    .res_ready_pin(res_ready_pin), .core_power_on(core_power_on), .core_reset_req(core_reset_req),
    .abort_tasks(abort_tasks), .ram_power(ram_power), .blk_run(blk_run), .task_grant(task_grant),
    .res_enable(res_enable), .buck_converter_en(buck_converter_en), .buck_bypass(buck_bypass),
    .wake_detect_en(wake_detect_en)
  );

  res_model u_res_model (.clock(clock), .slow(slow), .res_enable(res_enable), .res_ready(res_ready_pin));

  // 10 MHz clock
  initial clock = 1'b0;
  always #50 clock = ~clock;

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Wait n edges, then let outputs settle
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : cyc

  // One-cycle register write
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus.wr <= 1'b0;
  endtask : bus_wr

  // One-cycle register read, data checked in the following cycle
  task automatic bus_rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    bus.rd <= 1'b0;
    #1;
    chk(rd_data, exp);
  endtask : bus_rd

  // Registers, reserved bits and an unmapped address
  task automatic t_regs;
    bus_rd(ADDR_WAKE_CAUSE, 32'h1);
    bus_wr(ADDR_CTRL, 32'hFFFFFFFF);
    bus_rd(ADDR_CTRL, 32'h1F);
    cyc(1);
    chk(rd_data, 32'h0);
    bus_wr(8'h40, 32'h5);
    bus_rd(8'h40, 32'h0);
    bus_wr(ADDR_RETAIN, 32'h3);
    bus_rd(ADDR_RETAIN, 32'h3);
  endtask : t_regs

  // Sleep sub-modes decide which resources stay on
  task automatic t_modes;
    bus_wr(ADDR_CTRL, 32'h0);
    cyc(2);
    chk(res_enable, 32'h00);
    bus_wr(ADDR_CTRL, 32'h1);
    cyc(2);
    chk(res_enable, 32'h1C);
    bus_wr(ADDR_CTRL, 32'h7);
    cyc(2);
    chk(res_enable, 32'h1B);
  endtask : t_modes

  // Blocks run independently; a task waits for slow resources
  task automatic t_task;
    int n;
    bus_wr(ADDR_CTRL, 32'h0);
    slow <= 1'b1;
    blk_need <= 4'h9;
    cyc(2);
    chk(blk_run, 32'h9);
    blk_need <= 4'h0;
    cyc(4);
    @(posedge clock);
    task_req <= 4'h4;
    @(posedge clock);
    task_req <= 4'h0;
    cyc(1);
    chk(blk_run, 32'h4);
    for (n = 0; n < 80 && !task_grant[2]; n++) cyc(1);
    chk({31'h0, n >= 18}, 32'h1);
    chk(task_grant, 32'h4);
    cyc(1);
    chk(task_grant, 32'h0);
  endtask : t_task

  // Buck follows radio events and the linear-only option
  task automatic t_buck;
    logic [4:0] c [4] = '{5'h08, 5'h08, 5'h18, 5'h00};
    logic       r [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
    logic       e [4] = '{1'b1, 1'b0, 1'b0, 1'b0};
    for (int i = 0; i < 4; i++) begin
      bus_wr(ADDR_CTRL, {27'h0, c[i]});
      radio_active <= r[i];
      cyc(2);
      chk({buck_converter_en, buck_bypass}, {e[i], !e[i]});
    end
  endtask : t_buck

  // Off entry and wake by each pin source
  task automatic t_off;
    int n;
    for (int k = 0; k < 2; k++) begin
      bus_wr(ADDR_WAKE_CFG, 32'h1 << k);
      bus_wr(ADDR_RETAIN, k + 1);
      bus_wr(ADDR_WAKE_CAUSE, 32'h7);
      bus_wr(ADDR_OFF_CMD, 32'h1);
      #1;
      chk({abort_tasks, core_power_on}, 32'h2);
      chk(ram_power, k + 1);
      cyc(1);
      chk({abort_tasks, wake_detect_en}, 32'h1 << k);
      chk({res_enable, blk_run, buck_converter_en}, 32'h0);
      @(posedge clock);
      {comparator_wake_signal, gpio_detect_pin} <= 2'h2 >> k;
      cyc(8);
      chk(core_power_on, 32'h0);
      {comparator_wake_signal, gpio_detect_pin} <= 2'h1 << k;
      for (n = 0; n < 10 && !core_power_on; n++) cyc(1);
      chk({core_reset_req, ram_power}, 32'h7);
      {comparator_wake_signal, gpio_detect_pin} <= 2'h0;
      cyc(2);
      chk(core_reset_req, 32'h0);
      bus_rd(ADDR_WAKE_CAUSE, 32'h2 << k);
    end
  endtask : t_off

  // Unarmed pins keep the system off; only a reset brings it back
  task automatic t_rst_wake;
    bus_wr(ADDR_WAKE_CFG, 32'h0);
    bus_wr(ADDR_RETAIN, 32'h1);
    bus_wr(ADDR_WAKE_CAUSE, 32'h7);
    bus_wr(ADDR_OFF_CMD, 32'h1);
    @(posedge clock);
    {comparator_wake_signal, gpio_detect_pin} <= 2'h3;
    cyc(6);
    chk({core_power_on, wake_detect_en, ram_power}, 32'h1);
    @(posedge clock);
    {comparator_wake_signal, gpio_detect_pin} <= 2'h0;
    sys_rst <= 1'b1;
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0;
    #1;
    chk({core_power_on, core_reset_req, ram_power}, 32'hF);
    cyc(1);
    chk({core_power_on, core_reset_req, abort_tasks}, 32'h4);
    bus_rd(ADDR_RETAIN, 32'h0);
    bus_rd(ADDR_WAKE_CAUSE, 32'h1);
  endtask : t_rst_wake

  // Verdict and end of run
  task automatic stop_test;
    if (bad_count == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test

  // Watchdog against a hang
  initial begin
    repeat (5000) @(posedge clock);
    bad_count++;
    stop_test;
  end

  // Main sequence
  initial begin
    bus = '0;
    sys_rst = 1'b1;
    cpu_sleep = 1'b1;
    blk_need = '0;
    task_req = '0;
    radio_active = 1'b0;
    gpio_detect_pin = 1'b0;
    comparator_wake_signal = 1'b0;
    slow = 1'b0;
    cyc(19);
    chk({core_power_on, core_reset_req, abort_tasks, ram_power, buck_bypass, wake_detect_en, blk_run},
        32'hDC0);
    @(posedge clock);
    sys_rst <= 1'b0;
    t_regs;
    t_modes;
    t_task;
    t_buck;
    t_off;
    t_rst_wake;
    stop_test;
  end
endmodule : system_power_mode_control_bench
